// ### rtl/general_timer_unit.sv
// Five-timer general purpose timer unit with APB register access
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Five 16-bit timers, three plus two.
// - Timers run alone or chain within module.
// - Core timer has four selectable modes, its neighbours six.
// - Timer mode counts prescaled system clock ticks.
// - Counter mode counts selected input pin edges.
// - Gated mode counts ticks while gate level matches.
// - First module steps at most every 4 clocks.
// - Direction from software bit or direction pin.
// - Encoder mode decodes quadrature A/B phases.
// - Core latch toggles on wrap, drives pin/neighbours.
// - Neighbour in capture/reload role stops counting.
// - Capture role latches core value on pin edge.
// - Reload role loads core on pin or latch edge.
// - Opposite latch edges alternate reloads into core.
// - Second module steps at most every 2 clocks.
// - Second timers prescaled or external, direction selectable.
// - Second upper latch toggles, clocks lower, drives pin.
// - Second upper wrap clocks out and reloads itself.
// - Capture pin edge latches second lower, optional clear.
// - Core input/direction transitions also trigger capture.
module general_timer_unit
    import general_timer_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pins_t pins,
    output logic core_toggle_output,
    output logic second_toggle_output,
    output logic second_overflow_clock,
    output logic [5:0] request_flags
);

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] ctrl [NUM_TIMERS];
    logic [15:0] value [NUM_TIMERS];
    logic [15:0] next_value [NUM_TIMERS];
    logic [15:0] crr;
    logic [4:0] capctl;
    logic [9:0] divcnt;
    pins_t prev1;
    pins_t prev2;
    logic core_latch;
    logic core_latch_d;
    logic second_latch;
    logic second_latch_d;
    logic next_core_latch;
    logic next_second_latch;
    logic [NUM_TIMERS-1:0] cnt_ev;
    logic [NUM_TIMERS-1:0] down;
    logic [NUM_TIMERS-1:0] ovf;
    logic [NUM_TIMERS-1:0] wr_val;
    logic [NUM_TIMERS-1:0] wr_ctrl;
    logic [NUM_TIMERS-1:0] aux_cap;
    logic [NUM_TIMERS-1:0] aux_rel;
    logic cap_ev;
    logic base1;
    logic base2;
    logic acc;
    logic wr;
    logic [31:0] next_prdata;
    logic unmapped;

    function automatic logic edge_hit(input logic now, input logic prev,
                                      input logic [1:0] sel);
        edge_hit = (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
    endfunction

    function automatic logic tick_at(input logic [9:0] c, input logic [2:0] presc,
                                     input logic [3:0] base_log2);
        logic [9:0] m;
        m = ~(10'h3ff << ({1'b0, presc} + base_log2));
        tick_at = (c & m) == m;
    endfunction

    // ************************************************************
    // APB decode
    // ************************************************************
    // One wait state: pready rises one edge into the access phase
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;

    always_comb begin
        next_prdata = 32'h0000_0000;
        unmapped = 1'b1;
        wr_val = '0;
        wr_ctrl = '0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (paddr == ADDR_CTRL + ADDR_STRIDE * 8'(i)) begin
                next_prdata = {16'h0000, ctrl[i]};
                unmapped = 1'b0;
                wr_ctrl[i] = wr;
            end
            if (paddr == ADDR_VALUE + ADDR_STRIDE * 8'(i)) begin
                next_prdata = {16'h0000, value[i]};
                unmapped = 1'b0;
                wr_val[i] = wr;
            end
        end
        case (paddr)
            ADDR_CRR: begin
                next_prdata = {16'h0000, crr};
                unmapped = 1'b0;
            end
            ADDR_CAPCTL: begin
                next_prdata = {27'h0000000, capctl};
                unmapped = 1'b0;
            end
            ADDR_FLAGS: begin
                next_prdata = {26'h0000000, request_flags};
                unmapped = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & unmapped;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                ctrl[i] <= CTRL_RST;
            end
            capctl <= CAPCTL_RST;
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (wr_ctrl[i]) begin
                    ctrl[i] <= pwdata[15:0];
                end
            end
            if (wr && paddr == ADDR_CAPCTL) begin
                capctl <= pwdata[4:0];
            end
        end
    end

    // ************************************************************
    // Prescaler and pin sampling
    // ************************************************************
    // Free divider shared by both modules; base ticks set the finest step
    assign base1 = divcnt[1:0] == 2'(BASE1_CYCLES - 1);
    assign base2 = divcnt[0] == 1'(BASE2_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divcnt <= 10'h000;
            prev1 <= '0;
            prev2 <= '0;
        end else begin
            divcnt <= 10'(divcnt + 10'h001);
            // Pins only seen at base ticks so no faster count is possible
            if (base1) begin
                prev1 <= pins;
            end
            if (base2) begin
                prev2 <= pins;
            end
        end
    end

    // ************************************************************
    // Count events and direction
    // ************************************************************
    always_comb begin
        logic [2:0] mode;
        logic [15:0] c;
        logic tick;
        logic gate_in;
        logic ein;
        logic lat_ev;
        logic a_chg;
        logic b_chg;
        mode = MODE_TIMER;
        c = CTRL_RST;
        tick = 1'b0;
        gate_in = 1'b0;
        ein = 1'b0;
        lat_ev = 1'b0;
        a_chg = 1'b0;
        b_chg = 1'b0;
        cnt_ev = '0;
        down = '0;
        aux_cap = '0;
        aux_rel = '0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            c = ctrl[i];
            mode = c[F_MODE+:3];
            if (i <= T_UPPER) begin
                tick = base1 && tick_at(divcnt, c[F_PRESC+:3], BASE1_LOG2);
                gate_in = pins.in1[i];
                ein = base1 && edge_hit(pins.in1[i], prev1.in1[i], c[F_EDGE+:2]);
                lat_ev = edge_hit(core_latch, core_latch_d, c[F_EDGE+:2]);
                a_chg = base1 && (pins.in1[i] != prev1.in1[i]);
                b_chg = base1 && (pins.dir1[i] != prev1.dir1[i]);
                down[i] = c[F_DOWN] ^ (c[F_EXTDIR] & pins.dir1[i]);
            end else begin
                tick = base2 && tick_at(divcnt, c[F_PRESC+:3], BASE2_LOG2);
                gate_in = pins.in2[i-T_SLOWER];
                ein = base2 && edge_hit(pins.in2[i-T_SLOWER], prev2.in2[i-T_SLOWER],
                                        c[F_EDGE+:2]);
                lat_ev = edge_hit(second_latch, second_latch_d, c[F_EDGE+:2]);
                a_chg = 1'b0;
                b_chg = 1'b0;
                down[i] = c[F_DOWN] ^ (c[F_EXTDIR] & pins.dir2[i-T_SLOWER]);
            end
            case (mode)
                MODE_TIMER: cnt_ev[i] = c[F_RUN] & tick;
                MODE_GATED: cnt_ev[i] = c[F_RUN] & tick & (gate_in == c[F_GATEHI]);
                MODE_COUNTER: begin
                    // Chained neighbours count the partner latch instead of the pin
                    if (c[F_LATCHCLK] && i != T_CORE && i != T_SUPPER) begin
                        cnt_ev[i] = c[F_RUN] & lat_ev;
                    end else begin
                        cnt_ev[i] = c[F_RUN] & ein;
                    end
                end
                MODE_ENCODER: begin
                    if (i <= T_UPPER) begin
                        cnt_ev[i] = c[F_RUN] & (a_chg | b_chg);
                        down[i] = c[F_DOWN] ^ (a_chg ? (pins.in1[i] == pins.dir1[i])
                                                     : (pins.in1[i] != pins.dir1[i]));
                    end
                end
                MODE_RELOAD: begin
                    // Stopped while acting as register for the core timer
                    if (i == T_LOWER || i == T_UPPER) begin
                        aux_rel[i] = ein | edge_hit(core_latch, core_latch_d,
                                                   c[F_LEDGE+:2]);
                    end
                end
                MODE_CAPTURE: begin
                    if (i == T_LOWER || i == T_UPPER) begin
                        aux_cap[i] = ein;
                    end
                end
                default: cnt_ev[i] = 1'b0;
            endcase
            ovf[i] = cnt_ev[i] & (down[i] ? value[i] == VALUE_RST : value[i] == VALUE_TOP);
        end
    end

    // Second module capture from its own pin or the core timer pins
    assign cap_ev = base2 & (edge_hit(pins.cap, prev2.cap, capctl[C_EDGE+:2])
                  | (capctl[C_CORE_IN] & (pins.in1[T_CORE] != prev2.in1[T_CORE]))
                  | (capctl[C_CORE_DIR] & (pins.dir1[T_CORE] != prev2.dir1[T_CORE])));

    assign next_core_latch = core_latch ^ ovf[T_CORE];
    assign next_second_latch = second_latch ^ ovf[T_SUPPER];

    // ************************************************************
    // Timer values
    // ************************************************************
    // Software writes win over hardware in the same cycle
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (wr_val[i]) begin
                next_value[i] = pwdata[15:0];
            end else if (i == T_CORE && aux_rel[T_LOWER]) begin
                next_value[i] = value[T_LOWER];
            end else if (i == T_CORE && aux_rel[T_UPPER]) begin
                next_value[i] = value[T_UPPER];
            end else if (aux_cap[i]) begin
                next_value[i] = value[T_CORE];
            end else if (i == T_SLOWER && cap_ev && capctl[C_CLEAR]) begin
                next_value[i] = VALUE_RST;
            end else if (i == T_SUPPER && ovf[i] && ctrl[i][F_RELOAD]) begin
                next_value[i] = crr;
            end else if (cnt_ev[i]) begin
                next_value[i] = down[i] ? 16'(value[i] - 16'h0001)
                                        : 16'(value[i] + 16'h0001);
            end else begin
                next_value[i] = value[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                value[i] <= VALUE_RST;
            end
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                value[i] <= next_value[i];
            end
        end
    end

    // ************************************************************
    // Capture/reload register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crr <= VALUE_RST;
        end else if (cap_ev) begin
            crr <= value[T_SLOWER];
        end else if (wr && paddr == ADDR_CRR) begin
            crr <= pwdata[15:0];
        end
    end

    // ************************************************************
    // Toggle latches and outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_latch <= 1'b0;
            core_latch_d <= 1'b0;
            second_latch <= 1'b0;
            second_latch_d <= 1'b0;
            core_toggle_output <= 1'b0;
            second_toggle_output <= 1'b0;
            second_overflow_clock <= 1'b0;
        end else begin
            core_latch <= next_core_latch;
            core_latch_d <= core_latch;
            second_latch <= next_second_latch;
            second_latch_d <= second_latch;
            core_toggle_output <= next_core_latch & ctrl[T_CORE][F_OUTEN];
            second_toggle_output <= next_second_latch & ctrl[T_SUPPER][F_OUTEN];
            second_overflow_clock <= ovf[T_SUPPER];
        end
    end

    // ************************************************************
    // Request flags
    // ************************************************************
    // Write one to clear; a new event in the same cycle still sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flags <= FLAGS_RST;
        end else begin
            request_flags <= (request_flags & ~((wr && paddr == ADDR_FLAGS) ? pwdata[5:0]
                                                                              : 6'h00))
                           | {cap_ev, ovf | aux_cap};
        end
    end

endmodule // general_timer_unit

`default_nettype wire

// ### rtl/general_timer_unit_pkg.sv
// Constants, field layout and pin bundle of the general timer unit
package general_timer_unit_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VALUE = 8'h14;
    localparam logic [7:0] ADDR_STRIDE = 8'h04;
    localparam logic [7:0] ADDR_CRR = 8'h28;
    localparam logic [7:0] ADDR_CAPCTL = 8'h2c;
    localparam logic [7:0] ADDR_FLAGS = 8'h30;

    // ************************************************************
    // Timer indices
    // ************************************************************
    localparam int NUM_TIMERS = 5;
    localparam int T_LOWER = 0;
    localparam int T_CORE = 1;
    localparam int T_UPPER = 2;
    localparam int T_SLOWER = 3;
    localparam int T_SUPPER = 4;

    // ************************************************************
    // Control word fields
    // ************************************************************
    localparam int F_MODE = 0;
    localparam int F_PRESC = 3;
    localparam int F_RUN = 6;
    localparam int F_DOWN = 7;
    localparam int F_EXTDIR = 8;
    localparam int F_EDGE = 9;
    localparam int F_GATEHI = 11;
    localparam int F_LATCHCLK = 12;
    localparam int F_RELOAD = 12;
    localparam int F_OUTEN = 13;
    localparam int F_LEDGE = 14;

    localparam int C_EDGE = 0;
    localparam int C_CORE_IN = 2;
    localparam int C_CORE_DIR = 3;
    localparam int C_CLEAR = 4;

    localparam int FLAG_CAPTURE = 5;

    // ************************************************************
    // Modes
    // ************************************************************
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_GATED = 3'h1;
    localparam logic [2:0] MODE_COUNTER = 3'h2;
    localparam logic [2:0] MODE_ENCODER = 3'h3;
    localparam logic [2:0] MODE_RELOAD = 3'h4;
    localparam logic [2:0] MODE_CAPTURE = 3'h5;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [4:0] CAPCTL_RST = 5'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [15:0] VALUE_TOP = 16'hffff;
    localparam logic [3:0] BASE1_LOG2 = 4'h2;
    localparam logic [3:0] BASE2_LOG2 = 4'h1;
    localparam int BASE1_CYCLES = 1 << BASE1_LOG2;
    localparam int BASE2_CYCLES = 1 << BASE2_LOG2;

    typedef struct packed {
        logic [2:0] in1;
        logic [2:0] dir1;
        logic [1:0] in2;
        logic [1:0] dir2;
        logic cap;
    } pins_t;

endpackage

// ### tb/encoder_pins_model.sv
// Quadrature encoder and event pin model facing the timer unit
`timescale 1ns/100ps
`default_nettype none
module encoder_pins_model
    import general_timer_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enc_on,
    input wire logic enc_step,
    input wire logic enc_fwd,
    input wire pins_t ext,
    output var pins_t pins
);
    // ************************************************************
    // Shaft position as a two-bit phase
    // ************************************************************
    logic [1:0] phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
        end else if (enc_step) begin
            phase <= enc_fwd ? phase + 2'h1 : phase - 2'h1;
        end
    end

    // Phase A leads B going forward
    always_comb begin
        pins = ext;
        if (enc_on) begin
            pins.in1[T_CORE] = phase[0] ^ phase[1];
            pins.dir1[T_CORE] = phase[1];
        end
    end
endmodule // encoder_pins_model
`default_nettype wire

// ### tb/general_timer_unit_bench.sv
// Self-checking bench of the general timer unit
`timescale 1ns/100ps
`default_nettype none
module general_timer_unit_bench;
    import general_timer_unit_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic enc_on = 1'b0, enc_step = 1'b0, enc_fwd = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, errv, dn, core_toggle_output, second_toggle_output;
    logic second_overflow_clock;
    logic [31:0] prdata, rdv, v0;
    logic [5:0] request_flags;
    logic [2:0] p;
    pins_t ext = '0;
    pins_t pins;
    int failures = 0, n_checks = 0, seed = 32'hba277d5c, n;

    general_timer_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .core_toggle_output(core_toggle_output),
        .second_toggle_output(second_toggle_output),
        .second_overflow_clock(second_overflow_clock), .request_flags(request_flags));
    encoder_pins_model enc (.pclk(pclk), .presetn(presetn), .enc_on(enc_on),
        .enc_step(enc_step), .enc_fwd(enc_fwd), .ext(ext), .pins(pins));

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ************************************************************
    // Bus, pin and checking tasks
    // ************************************************************
    task test_done;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            test_done;
        end
    endtask

    task pulse(input int b);
        @(posedge pclk);
        ext[b] <= 1'b1;
        repeat (8) @(posedge pclk);
        ext[b] <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // Random spacing so the decoder sees both slow and prompt steps
    task step(input logic f);
        @(posedge pclk);
        enc_fwd <= f;
        enc_step <= 1'b1;
        @(posedge pclk);
        enc_step <= 1'b0;
        repeat (4 + $unsigned($random(seed)) % 8) @(posedge pclk);
    endtask

    function logic [7:0] va(int t);
        return ADDR_VALUE + 8'(ADDR_STRIDE * t);
    endfunction
    function logic [7:0] ca(int t);
        return ADDR_CTRL + 8'(ADDR_STRIDE * t);
    endfunction
    function logic [31:0] ctl(logic [2:0] m, logic [2:0] pr, logic d, logic [1:0] e, logic g,
                              logic o);
        return 32'({o, 1'b0, g, e, 1'b0, d, 1'b1, pr, m});
    endfunction
    function logic [15:0] span_exp(int lg, logic [2:0] pr, logic d);
        int k;
        k = 64 >> (lg + pr);
        return d ? 16'(-k) : 16'(k);
    endfunction

    // Two reads 64 clocks apart; the difference is the tick count
    task span(input int t, input logic [31:0] c, input logic [15:0] exp);
        apb(1'b1, va(t), 32'h8000);
        apb(1'b1, ca(t), c);
        apb(1'b0, va(t), 32'h0);
        v0 = rdv;
        repeat (60) @(posedge pclk);
        apb(1'b0, va(t), 32'h0);
        chk({16'h0, rdv[15:0] - v0[15:0]}, {16'h0, exp});
        apb(1'b1, ca(t), 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int t = 0; t < NUM_TIMERS; t++) begin
            apb(1'b0, ca(t), 32'h0);
            chk(rdv, 32'(CTRL_RST));
            apb(1'b1, va(t), 32'hdead_beef);
            apb(1'b0, va(t), 32'h0);
            chk(rdv, 32'h0000_beef);
        end
        apb(1'b0, ADDR_CAPCTL, 32'h0);
        chk(rdv, 32'(CAPCTL_RST));
        apb(1'b0, 8'h40, 32'h0);
        chk({rdv[30:0], errv}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            n = $unsigned($random(seed)) % NUM_TIMERS;
            p = 3'($unsigned($random(seed)) % 3);
            dn = 1'($random(seed));
            span(n, ctl(MODE_TIMER, p, dn, 2'h0, 1'b0, 1'b0),
                 span_exp(n < T_SLOWER ? BASE1_LOG2 : BASE2_LOG2, p, dn));
        end
        for (int g = 0; g < 2; g++) begin
            ext.in1[T_LOWER] <= 1'(g);
            span(T_LOWER, ctl(MODE_GATED, 3'h0, 1'b0, 2'h0, 1'b1, 1'b0),
                 g ? span_exp(BASE1_LOG2, 3'h0, 1'b0) : 16'h0);
        end
        ext.in1[T_LOWER] <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            ext.dir1[T_LOWER] <= 1'(k);
            apb(1'b1, va(T_LOWER), 32'h0);
            apb(1'b1, ca(T_LOWER), ctl(MODE_COUNTER, 3'h0, 1'b0, 2'h1, 1'b0, 1'b0) | 32'h100);
            n = 1 + $unsigned($random(seed)) % 8;
            repeat (n) pulse(8 + T_LOWER);
            apb(1'b0, va(T_LOWER), 32'h0);
            chk(rdv, {16'h0, k ? 16'(-n) : 16'(n)});
        end
        apb(1'b1, ca(T_LOWER), 32'h0);
        enc_on <= 1'b1;
        apb(1'b1, va(T_CORE), 32'h0);
        apb(1'b1, ca(T_CORE), ctl(MODE_ENCODER, 3'h0, 1'b0, 2'h0, 1'b0, 1'b0));
        for (int s = 0; s < 12; s++) step(s < 10);
        apb(1'b0, va(T_CORE), 32'h0);
        chk(rdv, 32'h8);
        apb(1'b1, ca(T_CORE), 32'h0);
        enc_on <= 1'b0;
        apb(1'b1, va(T_CORE), 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'h3f);
        apb(1'b1, ca(T_CORE), ctl(MODE_TIMER, 3'h0, 1'b1, 2'h0, 1'b0, 1'b1));
        repeat (4) @(posedge pclk);
        apb(1'b1, ca(T_CORE), 32'h2000);
        chk({core_toggle_output, request_flags[T_CORE]}, 32'h3);
        apb(1'b1, ADDR_FLAGS, 32'h2);
        @(negedge pclk);
        chk(request_flags[T_CORE], 32'h0);
        apb(1'b1, va(T_CORE), 32'h1234);
        apb(1'b1, ca(T_UPPER), ctl(MODE_CAPTURE, 3'h0, 1'b0, 2'h1, 1'b0, 1'b0));
        repeat (2) pulse(8 + T_UPPER);
        apb(1'b0, va(T_UPPER), 32'h0);
        chk({request_flags[T_UPPER], rdv[30:0]}, 32'h8000_1234);
        apb(1'b1, va(T_LOWER), 32'h0abc);
        apb(1'b1, ca(T_LOWER), ctl(MODE_RELOAD, 3'h0, 1'b0, 2'h1, 1'b0, 1'b0));
        pulse(8 + T_LOWER);
        apb(1'b0, va(T_CORE), 32'h0);
        chk(rdv, 32'h0abc);
        apb(1'b1, ca(T_LOWER), 32'h0);
        apb(1'b1, va(T_SUPPER), 32'hfffe);
        apb(1'b1, ca(T_SUPPER), ctl(MODE_TIMER, 3'h0, 1'b0, 2'h0, 1'b0, 1'b1));
        n = 0;
        while (second_overflow_clock !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        @(negedge pclk);
        chk({n < 40, second_toggle_output, request_flags[T_SUPPER]}, 32'h7);
        apb(1'b1, ca(T_SUPPER), 32'h0);
        apb(1'b1, va(T_SLOWER), 32'h0555);
        apb(1'b1, ADDR_CAPCTL, 32'h11);
        pulse(0);
        apb(1'b0, ADDR_CRR, 32'h0);
        chk(rdv, 32'h0555);
        apb(1'b0, va(T_SLOWER), 32'h0);
        chk({request_flags[FLAG_CAPTURE], rdv[30:0]}, 32'h8000_0000);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, va(T_SLOWER), 32'h0700 + k);
            apb(1'b1, ADDR_CAPCTL, 32'h4 << k);
            pulse(k ? 5 + T_CORE : 8 + T_CORE);
            apb(1'b0, ADDR_CRR, 32'h0);
            chk(rdv, 32'h0700 + k);
        end
        test_done;
    end
endmodule // general_timer_unit_bench
`default_nettype wire

// ### tb/general_timer_unit_monitor.sv
// Port checker of the general timer unit
`timescale 1ns/100ps
`default_nettype none
module general_timer_unit_monitor
    import general_timer_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pins_t pins,
    input wire logic core_toggle_output,
    input wire logic second_toggle_output,
    input wire logic second_overflow_clock,
    input wire logic [5:0] request_flags
);
    // ************************************************************
    // Bus handshake and event flags
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire logic wr_flags = psel && penable && pready && pwrite && paddr == ADDR_FLAGS;

    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_answer: assert property ((psel && penable && !pready) |=> pready)
        else $error("access phase not answered after one wait state");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_err_unmapped: assert property (pslverr |-> (paddr[1:0] != 2'h0 || paddr > ADDR_FLAGS))
        else $error("error response on a mapped address");
    a_err_readzero: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_wrap_pulse: assert property (second_overflow_clock |=> !second_overflow_clock)
        else $error("second module wrap pulses on consecutive cycles");
    a_wrap_flag: assert property (second_overflow_clock |-> request_flags[T_SUPPER])
        else $error("second module wrap without its flag");
    a_flags_sticky: assert property ((|($past(request_flags) & ~request_flags)) |-> $past(wr_flags))
        else $error("flag cleared without a flag write");

    c_wrap: cover property (second_overflow_clock);
    c_refused: cover property (pslverr);
    c_capture: cover property ($rose(request_flags[FLAG_CAPTURE]));
endmodule // general_timer_unit_monitor

bind general_timer_unit general_timer_unit_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .core_toggle_output(core_toggle_output),
    .second_toggle_output(second_toggle_output),
    .second_overflow_clock(second_overflow_clock), .request_flags(request_flags));
`default_nettype wire
